// file: vil_defs.svh
// Register indices, field positions, reset values and vectors of the interrupt logic.
// Assumes a 32-bit Wishbone slave: byte address = 4 * register index.
`ifndef VIL_DEFS_SVH
`define VIL_DEFS_SVH

// Register indices
`define VIL_IDX_TIMER0_STATUS 6'h05
`define VIL_IDX_CPU_STATUS 6'h06
`define VIL_IDX_CORE_STATUS 6'h07
`define VIL_IDX_FLAGS_TWO 6'h10
`define VIL_IDX_ENABLES_TWO 6'h11
`define VIL_IDX_FLAGS_ONE 6'h16
`define VIL_IDX_ENABLES_ONE 6'h17

// CPU status, timer0 status and core status fields
`define VIL_DISABLE_BIT 4
`define VIL_PIN_POL_BIT 7
`define VIL_CNT_SEL_BIT 6
`define VIL_PEND_BIT 7
`define VIL_CNT_FLAG_BIT 6
`define VIL_T0_FLAG_BIT 5
`define VIL_PIN_FLAG_BIT 4
`define VIL_GRP_EN_BIT 3

// First peripheral flag register fields
`define VIL_NOTIFY_BIT 7
`define VIL_T3_BIT 6
`define VIL_T2_BIT 5
`define VIL_T1_BIT 4
`define VIL_CAP2_BIT 3
`define VIL_CAP1_BIT 2
`define VIL_TX_BIT 1
`define VIL_RX_BIT 0

// Second peripheral flag register fields
`define VIL_SSP_BIT 7
`define VIL_BCOL_BIT 6
`define VIL_ADC_BIT 5
`define VIL_CAP4_BIT 3
`define VIL_CAP3_BIT 2

// Reset values and writable masks
`define VIL_FLAGS_RST 8'h02
`define VIL_FLAGS_ONE_WMASK 8'hfc
`define VIL_FLAGS_TWO_WMASK 8'hec
`define VIL_ENABLES_TWO_WMASK 8'hef
`define VIL_TIMER0_WMASK 8'hc0

// Vector addresses
`define VIL_VEC_RESET 16'h0000
`define VIL_VEC_PIN 16'h0008
`define VIL_VEC_T0 16'h0010
`define VIL_VEC_CNT 16'h0018
`define VIL_VEC_PERI 16'h0020

`endif

// file: vil_pkg.sv
// Types shared by the interrupt logic.
// Assumes vil_defs.svh holds all numeric constants.
package vil_pkg;
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_ENTRY = 3'b010,
    SEQ_EXIT = 3'b100
  } vil_seq_t;
endpackage : vil_pkg

// file: vil_edge_det.sv
// Edge detector with selectable polarity for one pin.
// Assumes the pin is already synchronous to clk_i.
`timescale 1ns/10ps
module vil_edge_det (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pin and polarity
  input wire logic pin_i,
  input wire logic rise_i,
  output logic edge_o
);
  logic prev_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_q <= pin_i; // Pin level, so release gives no false edge
    end else begin
      prev_q <= pin_i;
    end
  end

  // Rising when select is set, falling otherwise
  assign edge_o = rise_i ? (pin_i & ~prev_q) : (~pin_i & prev_q);
endmodule : vil_edge_det

// file: vil_prio_sel.sv
// Fixed priority selector of the four interrupt vectors.
// Assumes req_i bit 0 is the highest priority source.
`timescale 1ns/10ps
`include "vil_defs.svh"
module vil_prio_sel (
  // Requests
  input wire logic [3:0] req_i,
  // Winner
  output logic [3:0] grant_o,
  output logic [15:0] vec_o
);
  always_comb begin
    grant_o = 4'h0;
    vec_o = `VIL_VEC_PERI;
    if (req_i[0]) begin
      grant_o = 4'h1;
      vec_o = `VIL_VEC_PIN;
    end else if (req_i[1]) begin
      grant_o = 4'h2;
      vec_o = `VIL_VEC_T0;
    end else if (req_i[2]) begin
      grant_o = 4'h4;
      vec_o = `VIL_VEC_CNT;
    end else if (req_i[3]) begin
      grant_o = 4'h8;
    end
  end
endmodule : vil_prio_sel

// file: vil_irq_top.sv
// Vectored interrupt logic: flag, enable and core status registers, priority and entry/exit.
// Assumes synchronous inputs, a Wishbone classic master and a CPU sequencer holding the stack.
`timescale 1ns/10ps
`include "vil_defs.svh"
module vil_irq_top
  import vil_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // External pins
  input wire logic pin_edge_i,
  input wire logic counter_pin_i,
  // Peripheral events
  input wire logic timer0_ovf_i,
  input wire logic change_mismatch_i,
  input wire logic capture1_select_i,
  input wire logic timer3_ovf_i,
  input wire logic timer3_period_roll_i,
  input wire logic timer2_period_roll_i,
  input wire logic timer1_wide_mode_i,
  input wire logic timer1_period_roll_i,
  input wire logic timer21_period_roll_i,
  input wire logic [3:0] capture_i,
  input wire logic [1:0] usart_tx_empty_i,
  input wire logic [1:0] usart_rx_full_i,
  input wire logic ssp_event_i,
  input wire logic bus_collision_i,
  input wire logic conversion_done_i,
  // CPU sequencer
  input wire logic instr_end_i,
  input wire logic return_from_irq_i,
  input wire logic [15:0] stack_top_i,
  output logic stack_push_o,
  output logic stack_pop_o,
  output logic pc_load_o,
  output logic [15:0] pc_val_o,
  output logic global_irq_disable_o,
  output logic wake_o
);
  // Register state
  logic global_irq_disable_q;
  logic [7:0] timer0_status_q;
  logic [2:0] core_flags_q;
  logic [3:0] core_enables_q;
  logic [7:0] peripheral_flags_one_q;
  logic [7:0] peripheral_flags_two_q;
  logic [7:0] peripheral_enables_one_q;
  logic [7:0] peripheral_enables_two_q;
  logic reset_vec_q;
  vil_seq_t seq_q;

  // Bus decode
  logic bus_req, wr_en;
  logic [5:0] idx;
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_en = bus_req & wb_we_i & wb_sel_i[0];
  assign idx = wb_adr_i[7:2];

  logic wr_core, wr_cpu, wr_timer0, wr_flags_one, wr_flags_two, wr_enables_one, wr_enables_two;
  assign wr_core = wr_en && (idx == `VIL_IDX_CORE_STATUS);
  assign wr_cpu = wr_en && (idx == `VIL_IDX_CPU_STATUS);
  assign wr_timer0 = wr_en && (idx == `VIL_IDX_TIMER0_STATUS);
  assign wr_flags_one = wr_en && (idx == `VIL_IDX_FLAGS_ONE);
  assign wr_flags_two = wr_en && (idx == `VIL_IDX_FLAGS_TWO);
  assign wr_enables_one = wr_en && (idx == `VIL_IDX_ENABLES_ONE);
  assign wr_enables_two = wr_en && (idx == `VIL_IDX_ENABLES_TWO);

  // Pin edges, one detector per pin
  logic [1:0] pin_vec, pol_vec, edge_vec;
  assign pin_vec = {counter_pin_i, pin_edge_i};
  assign pol_vec = {timer0_status_q[`VIL_CNT_SEL_BIT], timer0_status_q[`VIL_PIN_POL_BIT]};
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_edge
      vil_edge_det u_edge (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(pin_vec[g]),
        .rise_i(pol_vec[g]),
        .edge_o(edge_vec[g])
      );
    end
  endgenerate

  // Core flag sets: {counter pin, timer0, pin}
  logic [2:0] core_set;
  assign core_set = {edge_vec[1], timer0_ovf_i, edge_vec[0]};

  // Peripheral flag sets
  logic t3_evt, t1_evt;
  logic [7:0] flags_one_set, flags_two_set;
  assign t3_evt = capture1_select_i ? timer3_ovf_i : timer3_period_roll_i;
  assign t1_evt = timer1_wide_mode_i ? timer21_period_roll_i : timer1_period_roll_i;
  always_comb begin
    flags_one_set = 8'h00;
    flags_one_set[`VIL_NOTIFY_BIT] = change_mismatch_i;
    flags_one_set[`VIL_T3_BIT] = t3_evt;
    flags_one_set[`VIL_T2_BIT] = timer2_period_roll_i;
    flags_one_set[`VIL_T1_BIT] = t1_evt;
    flags_one_set[`VIL_CAP2_BIT] = capture_i[1];
    flags_one_set[`VIL_CAP1_BIT] = capture_i[0];
    flags_two_set = 8'h00;
    flags_two_set[`VIL_SSP_BIT] = ssp_event_i;
    flags_two_set[`VIL_BCOL_BIT] = bus_collision_i;
    flags_two_set[`VIL_ADC_BIT] = conversion_done_i;
    flags_two_set[`VIL_CAP4_BIT] = capture_i[3];
    flags_two_set[`VIL_CAP3_BIT] = capture_i[2];
  end

  // Peripheral pending, combined over both register pairs
  logic [15:0] peri_terms;
  logic peripheral_pending;
  assign peri_terms = {peripheral_flags_two_q & peripheral_enables_two_q,
                       peripheral_flags_one_q & peripheral_enables_one_q};
  assign peripheral_pending = |peri_terms;

  // Requests and priority
  logic [3:0] req;
  logic [3:0] grant;
  logic [15:0] vec;
  assign req[0] = core_flags_q[0] & core_enables_q[0];
  assign req[1] = core_flags_q[1] & core_enables_q[1];
  assign req[2] = core_flags_q[2] & core_enables_q[2];
  assign req[3] = peripheral_pending & core_enables_q[`VIL_GRP_EN_BIT];

  vil_prio_sel u_prio (
    .req_i(req),
    .grant_o(grant),
    .vec_o(vec)
  );

  logic can_vector, accept, reset_take, ret_take;
  assign can_vector = (seq_q == SEQ_IDLE) && instr_end_i && !global_irq_disable_q;
  assign reset_take = can_vector && reset_vec_q;
  assign accept = can_vector && !reset_vec_q && (|req);
  assign ret_take = (seq_q == SEQ_IDLE) && return_from_irq_i && !accept && !reset_take;

  // Enable clear racing a set flag while interrupts are on
  logic [3:0] cur_flags, new_en;
  logic hazard;
  assign cur_flags = {peripheral_pending, core_flags_q | core_set};
  assign new_en = wb_dat_i[3:0];
  assign hazard = wr_core && !global_irq_disable_q &&
                  |(core_enables_q & ~new_en & cur_flags);

  // Entry/exit sequence
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_q <= SEQ_IDLE;
    end else begin
      case (seq_q)
        SEQ_IDLE: begin
          if (accept) begin
            seq_q <= SEQ_ENTRY;
          end else if (ret_take) begin
            seq_q <= SEQ_EXIT;
          end
        end
        SEQ_ENTRY: seq_q <= SEQ_IDLE;
        SEQ_EXIT: seq_q <= SEQ_IDLE;
        default: seq_q <= SEQ_IDLE;
      endcase
    end
  end

  // CPU side strobes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stack_push_o <= 1'b0;
      stack_pop_o <= 1'b0;
      pc_load_o <= 1'b0;
      pc_val_o <= `VIL_VEC_RESET;
    end else begin
      stack_push_o <= accept;
      stack_pop_o <= ret_take;
      pc_load_o <= accept | ret_take | reset_take;
      if (accept) begin
        pc_val_o <= vec;
      end else if (ret_take) begin
        pc_val_o <= stack_top_i;
      end else if (reset_take) begin
        pc_val_o <= `VIL_VEC_RESET;
      end
    end
  end

  // Global disable; hardware set on entry wins over a software write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      global_irq_disable_q <= 1'b1;
    end else if (accept || reset_take) begin
      global_irq_disable_q <= 1'b1;
    end else if (ret_take) begin
      global_irq_disable_q <= 1'b0;
    end else if (wr_cpu) begin
      global_irq_disable_q <= wb_dat_i[`VIL_DISABLE_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reset_vec_q <= 1'b0;
    end else if (hazard) begin
      reset_vec_q <= 1'b1;
    end else if (reset_take) begin
      reset_vec_q <= 1'b0;
    end
  end

  // Core flags and enables; a new edge beats both hardware and software clears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_flags_q <= 3'h0;
      core_enables_q <= 4'h0;
    end else begin
      if (wr_core) begin
        core_enables_q <= new_en;
        core_flags_q <= wb_dat_i[`VIL_CNT_FLAG_BIT:`VIL_PIN_FLAG_BIT] | core_set;
      end else begin
        core_flags_q <= (core_flags_q & ~(accept ? grant[2:0] : 3'h0)) | core_set;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer0_status_q <= 8'h00;
    end else if (wr_timer0) begin
      timer0_status_q <= wb_dat_i[7:0] & `VIL_TIMER0_WMASK;
    end
  end

  // Mask held as a net so its upper six bits can be sliced
  logic [7:0] flags_two_mask;
  assign flags_two_mask = `VIL_FLAGS_TWO_WMASK;

  // Peripheral flags; USART bits follow the hardware, set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      peripheral_flags_one_q <= `VIL_FLAGS_RST;
      peripheral_flags_two_q <= `VIL_FLAGS_RST;
    end else begin
      peripheral_flags_one_q[7:2] <= (wr_flags_one ? wb_dat_i[7:2] : peripheral_flags_one_q[7:2])
                                     | flags_one_set[7:2];
      peripheral_flags_two_q[7:2] <= ((wr_flags_two ? wb_dat_i[7:2] : peripheral_flags_two_q[7:2])
                                     | flags_two_set[7:2]) & flags_two_mask[7:2];
      peripheral_flags_one_q[`VIL_TX_BIT] <= usart_tx_empty_i[0];
      peripheral_flags_one_q[`VIL_RX_BIT] <= usart_rx_full_i[0];
      peripheral_flags_two_q[`VIL_TX_BIT] <= usart_tx_empty_i[1];
      peripheral_flags_two_q[`VIL_RX_BIT] <= usart_rx_full_i[1];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      peripheral_enables_one_q <= 8'h00;
      peripheral_enables_two_q <= 8'h00;
    end else begin
      if (wr_enables_one) begin
        peripheral_enables_one_q <= wb_dat_i[7:0];
      end
      if (wr_enables_two) begin
        peripheral_enables_two_q <= wb_dat_i[7:0] & `VIL_ENABLES_TWO_WMASK;
      end
    end
  end

  // Wake on enabled pin or counter pin flag or any enabled peripheral flag (not timer0), independent of global disable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_o <= 1'b0;
    end else begin
      wake_o <= req[0] | req[2] | peripheral_pending;
    end
  end

  assign global_irq_disable_o = global_irq_disable_q;

  // Read mux; unmapped words read zero
  logic [7:0] rd_byte;
  always_comb begin
    case (idx)
      `VIL_IDX_CORE_STATUS: rd_byte = {peripheral_pending, core_flags_q, core_enables_q};
      `VIL_IDX_CPU_STATUS: rd_byte = {3'h0, global_irq_disable_q, 4'h0};
      `VIL_IDX_TIMER0_STATUS: rd_byte = timer0_status_q;
      `VIL_IDX_FLAGS_ONE: rd_byte = peripheral_flags_one_q;
      `VIL_IDX_FLAGS_TWO: rd_byte = peripheral_flags_two_q;
      `VIL_IDX_ENABLES_ONE: rd_byte = peripheral_enables_one_q;
      `VIL_IDX_ENABLES_TWO: rd_byte = peripheral_enables_two_q;
      default: rd_byte = 8'h00;
    endcase
  end

  // One wait state: ack the cycle after the request, drop it next
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        wb_dat_o <= {24'h0, rd_byte};
      end
    end
  end

  AST_DISABLE_AFTER_RESET: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> global_irq_disable_o) else $error("global disable clear after reset");
  AST_ENTRY_ACTIONS: assert property (@(posedge clk_i) disable iff (rst_i)
    accept |=> global_irq_disable_o && stack_push_o && pc_load_o)
    else $error("entry did not push, load and disable");
  AST_RETURN_ACTIONS: assert property (@(posedge clk_i) disable iff (rst_i)
    ret_take |=> !global_irq_disable_o && stack_pop_o && pc_val_o == $past(stack_top_i))
    else $error("return did not restore pc or enable");
  AST_BLOCKED_WHEN_DISABLED: assert property (@(posedge clk_i) disable iff (rst_i)
    global_irq_disable_q |=> !stack_push_o) else $error("vectored while disabled");
  AST_PIN_TOP_PRIORITY: assert property (@(posedge clk_i) disable iff (rst_i)
    accept && req[0] |=> pc_val_o == `VIL_VEC_PIN) else $error("pin edge not first");
  AST_PERI_VECTOR: assert property (@(posedge clk_i) disable iff (rst_i)
    accept && req == 4'h8 |=> pc_val_o == `VIL_VEC_PERI ##1 !stack_push_o)
    else $error("peripheral vector wrong");
  AST_CAPTURE_SETS: assert property (@(posedge clk_i) disable iff (rst_i)
    capture_i[0] |=> peripheral_flags_one_q[`VIL_CAP1_BIT]) else $error("capture flag lost");
  AST_TX_FOLLOWS: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 peripheral_flags_one_q[`VIL_TX_BIT] == $past(usart_tx_empty_i[0]))
    else $error("tx flag not hardware driven");
  AST_CORE_AUTOCLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
    accept && grant[1] && !timer0_ovf_i && !wr_core |=> !core_flags_q[1])
    else $error("timer0 flag not cleared on vectoring");
endmodule : vil_irq_top

// file: vil_cpu_model.sv
// CPU sequencer model: marks instruction ends and returns, keeps the return stack.
// Assumes one push or pop pulse per cycle from the interrupt logic.
`timescale 1ns/10ps
module vil_cpu_model (
  // Clock
  input wire logic clk_i,
  // Stack strobes from the interrupt logic
  input wire logic stack_push_i,
  input wire logic stack_pop_i,
  // Sequencer outputs
  output logic instr_end_o,
  output logic return_from_irq_o,
  output logic [15:0] stack_top_o
);
  logic [15:0] stack_q [$];
  logic [15:0] ret_q = 16'h0100;

  initial begin
    instr_end_o = 1'b0;
    return_from_irq_o = 1'b0;
    stack_top_o = 16'h5a5a;
  end

  // Return addresses differ per push so a stale pop shows
  always @(posedge clk_i) begin
    if (stack_push_i === 1'b1) begin
      stack_q.push_back(ret_q);
      ret_q <= ret_q + 16'h0011;
    end
    if (stack_pop_i === 1'b1 && stack_q.size() != 0) begin
      void'(stack_q.pop_back());
    end
    // Empty stack shows a toggling pattern, never the last value
    stack_top_o <= (stack_q.size() != 0) ? stack_q[$] : ~stack_top_o;
  end

  // One-cycle strobe, then wait half a cycle so results have landed
  task automatic pulse(input bit ret);
    @(posedge clk_i);
    if (ret) begin
      return_from_irq_o <= 1'b1;
    end else begin
      instr_end_o <= 1'b1;
    end
    @(posedge clk_i);
    return_from_irq_o <= 1'b0;
    instr_end_o <= 1'b0;
    @(negedge clk_i);
  endtask : pulse
endmodule : vil_cpu_model

// file: tb.sv
// Self-checking bench for the vectored interrupt logic.
// Assumes the sequencer model vil_cpu_model and a Wishbone classic slave.
`timescale 1ns/10ps
module tb import vil_pkg::*;;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic pin_edge_i = 1'b0;
  logic counter_pin_i = 1'b0;
  logic change_mismatch_i = 1'b0;
  logic capture1_select_i = 1'b0;
  logic timer1_wide_mode_i = 1'b0;
  logic [12:0] ev_q = 13'h0;
  logic [1:0] usart_tx_empty_i = 2'b11;
  logic [1:0] usart_rx_full_i = 2'b00;
  logic instr_end_i;
  logic return_from_irq_i;
  logic [15:0] stack_top_i;
  logic stack_push_o;
  logic stack_pop_o;
  logic pc_load_o;
  logic [15:0] pc_val_o;
  logic global_irq_disable_o;
  logic wake_o;
  int checks = 0;
  int miscompares = 0;
  int cycles = 0;

  vil_irq_top dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'h1), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_edge_i(pin_edge_i),
    .counter_pin_i(counter_pin_i), .timer0_ovf_i(ev_q[0]),
    .change_mismatch_i(change_mismatch_i), .capture1_select_i(capture1_select_i),
    .timer3_ovf_i(ev_q[1]), .timer3_period_roll_i(ev_q[2]),
    .timer2_period_roll_i(ev_q[3]), .timer1_wide_mode_i(timer1_wide_mode_i),
    .timer1_period_roll_i(ev_q[4]), .timer21_period_roll_i(ev_q[5]),
    .capture_i(ev_q[12:9]), .usart_tx_empty_i(usart_tx_empty_i),
    .usart_rx_full_i(usart_rx_full_i), .ssp_event_i(ev_q[6]),
    .bus_collision_i(ev_q[7]), .conversion_done_i(ev_q[8]),
    .instr_end_i(instr_end_i), .return_from_irq_i(return_from_irq_i),
    .stack_top_i(stack_top_i), .stack_push_o(stack_push_o), .stack_pop_o(stack_pop_o),
    .pc_load_o(pc_load_o), .pc_val_o(pc_val_o),
    .global_irq_disable_o(global_irq_disable_o), .wake_o(wake_o)
  );

  vil_cpu_model cpu (
    .clk_i(clk_i), .stack_push_i(stack_push_o), .stack_pop_i(stack_pop_o),
    .instr_end_o(instr_end_i), .return_from_irq_o(return_from_irq_i),
    .stack_top_o(stack_top_i)
  );

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d, miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : check

  // Classic single cycle; waits for ack, no latency assumed
  task automatic wb(input logic [5:0] idx, input logic we, input logic [7:0] wd,
                    output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h0, wd};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
    end
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [7:0] v;
    wb(idx, 1'b1, d, v);
  endtask : wr

  task automatic rc(input logic [5:0] idx, input logic [7:0] exp, input string name);
    logic [7:0] v;
    wb(idx, 1'b0, 8'h00, v);
    check(name, 16'(v), 16'(exp));
  endtask : rc

  task automatic pulse_ev(input logic [12:0] m);
    @(posedge clk_i);
    ev_q <= m;
    @(posedge clk_i);
    ev_q <= 13'h0;
  endtask : pulse_ev

  // Instruction end (ret=0) or return (ret=1), judged half a cycle after the take
  task automatic op(input bit ret, input logic ld, input logic [15:0] pc);
    logic [15:0] top;
    cpu.pulse(ret);
    // Pop lands a cycle after the take, so the pushed top still stands here
    top = stack_top_i;
    check("pc_load", 16'(pc_load_o), 16'(ld));
    if (ld) begin
      check("pc_val", pc_val_o, ret ? top : pc);
      check("push", 16'(stack_push_o), 16'(!ret && pc != 16'h0));
      check("pop", 16'(stack_pop_o), 16'(ret));
      check("disable", 16'(global_irq_disable_o), 16'(!ret));
    end
  endtask : op

  task automatic t_reset();
    logic [7:0] v;
    wb(6'h06, 1'b0, 8'h00, v);
    check("disable_bit", 16'(v[4]), 16'h1);
    check("disable_out", 16'(global_irq_disable_o), 16'h1);
    rc(6'h16, 8'h02, "flags_one");
    rc(6'h10, 8'h02, "flags_two");
    $display("test reset done");
  endtask : t_reset

  task automatic t_periph();
    pulse_ev(13'h0022);
    rc(6'h16, 8'h02, "flags_one");
    @(posedge clk_i);
    change_mismatch_i <= 1'b1;
    usart_rx_full_i <= 2'b11;
    pulse_ev(13'h1fdc);
    change_mismatch_i <= 1'b0;
    capture1_select_i <= 1'b1;
    timer1_wide_mode_i <= 1'b1;
    rc(6'h16, 8'hff, "flags_one");
    rc(6'h10, 8'hef, "flags_two");
    wr(6'h16, 8'h00);
    wr(6'h10, 8'h00);
    rc(6'h16, 8'h03, "flags_one");
    rc(6'h10, 8'h03, "flags_two");
    pulse_ev(13'h0022);
    usart_tx_empty_i <= 2'b00;
    usart_rx_full_i <= 2'b00;
    rc(6'h16, 8'h50, "flags_one");
    rc(6'h10, 8'h00, "flags_two");
    usart_tx_empty_i <= 2'b11;
    // Flags cleared before any enable is set
    wr(6'h16, 8'h00);
    rc(6'h16, 8'h02, "flags_one");
    $display("test peripheral flags done");
  endtask : t_periph

  task automatic t_vectors();
    wr(6'h05, 8'h80);
    wr(6'h07, 8'h0f);
    @(posedge clk_i);
    pin_edge_i <= 1'b1;
    counter_pin_i <= 1'b1;
    pulse_ev(13'h0001);
    rc(6'h07, 8'h3f, "core_status");
    counter_pin_i <= 1'b0;
    rc(6'h07, 8'h7f, "core_status");
    check("wake", 16'(wake_o), 16'h1);
    op(1'b0, 1'b0, 16'h0);
    wr(6'h06, 8'h00);
    op(1'b0, 1'b1, 16'h0008);
    op(1'b1, 1'b1, 16'h0);
    op(1'b0, 1'b1, 16'h0010);
    op(1'b1, 1'b1, 16'h0);
    op(1'b0, 1'b1, 16'h0018);
    op(1'b1, 1'b1, 16'h0);
    rc(6'h07, 8'h0f, "core_status");
    pulse_ev(13'h0200);
    op(1'b0, 1'b0, 16'h0);
    wr(6'h17, 8'h04);
    rc(6'h07, 8'h8f, "core_status");
    op(1'b0, 1'b1, 16'h0020);
    rc(6'h07, 8'h8f, "core_status");
    op(1'b1, 1'b1, 16'h0);
    // Group enable dropped while the pending bit is set and interrupts are on
    wr(6'h07, 8'h00);
    op(1'b0, 1'b1, 16'h0000);
    // Routine clears the serviced flag, which ends the pending state
    wr(6'h16, 8'h00);
    rc(6'h07, 8'h00, "core_status");
    $display("test vectoring done");
  endtask : t_vectors

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_periph();
    t_vectors();
    summarize();
  end
endmodule : tb
